// ==== design/tts_pkg.sv ====
package tts_pkg;

  // ----------------------------------------
  // stream widths and sideband positions
  // ----------------------------------------
  localparam int DATA_W = 128;
  localparam int KEEP_W = 16;
  localparam int USER_W = 4;
  localparam int U_ECRC = 0;
  localparam int U_FWD  = 1;
  localparam int U_STR  = 2;
  localparam int U_DSC  = 3;

  // ----------------------------------------
  // header bit positions within dw0
  // ----------------------------------------
  localparam int HDR_TD    = 15;
  localparam int HDR_EP    = 14;
  localparam int HDR_TYPE0 = 24;

  // ----------------------------------------
  // end-of-frame keep codes
  // ----------------------------------------
  localparam logic [15:0] KEEP_1DW = 16'h000F;
  localparam logic [15:0] KEEP_2DW = 16'h00FF;
  localparam logic [15:0] KEEP_3DW = 16'h0FFF;
  localparam logic [15:0] KEEP_4DW = 16'hFFFF;

  // ----------------------------------------
  // digest and size limits
  // ----------------------------------------
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam int          MPS_W       = 3;
  localparam int          CNT_W       = 12;
  localparam logic [11:0] MPS_BASE_DW = 12'h020;
  localparam logic [11:0] HDR_MAX_DW  = 12'h004;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PKT    = 2'b01,
    ST_DIGEST = 2'b10,
    ST_CORE   = 2'b11
  } tts_state_t;

  function automatic logic [2:0] dw_count(input logic [15:0] keep);
    logic [2:0] n;
    n = 3'h4;
    if (keep == KEEP_1DW) n = 3'h1;
    else if (keep == KEEP_2DW) n = 3'h2;
    else if (keep == KEEP_3DW) n = 3'h3;
    return n;
  endfunction : dw_count

  function automatic logic [31:0] crc_dw(input logic [31:0] crc, input logic [31:0] dw);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      if (c[31] ^ dw[i]) c = {c[30:0], 1'b0} ^ CRC_POLY;
      else c = {c[30:0], 1'b0};
    end
    return c;
  endfunction : crc_dw

endpackage : tts_pkg

// ==== design/tts_beat_if.sv ====
`timescale 1ns/10ps
interface tts_beat_if;
  import tts_pkg::*;
  logic [DATA_W-1:0] data;
  logic [KEEP_W-1:0] keep;
  logic              valid;
  logic              first;
  logic              last;

  modport src (output data, output keep, output valid, output first, output last);
  modport dst (input data, input keep, input valid, input first, input last);
endinterface : tts_beat_if

// ==== design/tts_ecrc.sv ====
`timescale 1ns/10ps
module tts_ecrc
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // accepted beats
  tts_beat_if.dst          beat,
  // running remainder
  output logic [31:0]      crc_q
);

  logic [31:0] crc_d;

  // ----------------------------------------
  // fold valid dwords, variant bits forced
  // ----------------------------------------
  always_comb begin
    logic [31:0] dw;
    logic [2:0]  n;
    dw    = '0;
    n     = dw_count(beat.last ? beat.keep : KEEP_4DW);
    crc_d = beat.first ? CRC_INIT : crc_q;
    for (int k = 0; k < 4; k++) begin
      dw = beat.data[32*k +: 32];
      // type bit and poison may change after the digest is taken
      if (beat.first && k == 0) begin
        dw[HDR_TYPE0] = 1'b1;
        dw[HDR_EP]    = 1'b1;
      end
      if (3'(k) < n) crc_d = crc_dw(crc_d, dw);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) crc_q <= CRC_INIT;
    else if (beat.valid) crc_q <= crc_d;
  end

endmodule : tts_ecrc

// ==== design/tts_pkt_check.sv ====
`timescale 1ns/10ps
module tts_pkt_check
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // accepted beats
  tts_beat_if.dst               beat,
  // packet context
  input  wire logic             raw_valid,
  input  wire logic             in_pkt,
  input  wire logic             stream,
  input  wire logic [MPS_W-1:0] mps_code,
  // violations including the current beat
  output logic                  oversize,
  output logic                  src_gap
);

  logic [CNT_W-1:0] dw_cnt_q;
  logic [CNT_W-1:0] dw_cnt_d;
  logic [CNT_W-1:0] limit;
  logic             over_q;
  logic             gap_q;

  // header plus payload plus a possible digest
  assign limit    = CNT_W'(MPS_BASE_DW << mps_code) + HDR_MAX_DW + 12'h001;
  assign dw_cnt_d = (beat.first ? '0 : dw_cnt_q) + CNT_W'(dw_count(beat.last ? beat.keep : KEEP_4DW));
  assign oversize = beat.valid & ((over_q & !beat.first) | (dw_cnt_d > limit));
  assign src_gap  = gap_q & !beat.first;

  // ----------------------------------------
  // size counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dw_cnt_q <= '0;
      over_q   <= 1'b0;
    end else if (beat.valid) begin
      dw_cnt_q <= dw_cnt_d;
      over_q   <= oversize;
    end
  end

  // ----------------------------------------
  // cut-through source pause
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 1'b0;
    else if (beat.valid && beat.first) gap_q <= 1'b0;
    else if (in_pkt && stream && !raw_valid) gap_q <= 1'b1;
  end

endmodule : tts_pkt_check

// ==== design/tts_tx_port.sv ====
// How it works
// - beats with tvalid low are not accepted; inside a cut-through packet they count as a source pause
// - buffer-full throttle only between packets, lowering tready after tlast
// - once a packet starts, the port accepts it to the end without stalling
// - after a grant between packets, tready stays low until the core packet is sent
// - non-D0 power state blocks new packets once the current one ends
// - discontinue is ignored when no packet is in progress
// - discontinued packet: discarded when stored, nullified with EDB when cut-through
// - discard on link loss, oversize payload, or cut-through source pause
// - discarded packet still accepted; drop flag in the cycle after its end
// - poison-forward on any beat of a stored packet makes the sent header carry EP; cut-through packets get no EP
// - paused cut-through packet raises drop and goes out nullified
// - requested digest without TD: ecrc appended and TD set
// - digest insertion takes exactly one tready-low cycle at packet end
`timescale 1ns/10ps
module tts_tx_port
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  // transmit stream from the application
  input  wire logic [DATA_W-1:0] S_AXIS_TX_TDATA,
  input  wire logic [KEEP_W-1:0] S_AXIS_TX_TKEEP,
  input  wire logic              S_AXIS_TX_TLAST,
  input  wire logic [USER_W-1:0] S_AXIS_TX_TUSER,
  input  wire logic              S_AXIS_TX_TVALID,
  output logic                   S_AXIS_TX_TREADY,
  // core status
  input  wire logic              BUF_ROOM,
  input  wire logic              LINK_UP,
  input  wire logic              PM_NON_D0,
  input  wire logic [MPS_W-1:0]  MPS_CODE,
  // core-generated packet arbitration
  input  wire logic              CORE_TLP_PEND,
  output logic                   TX_CFG_REQ,
  input  wire logic              TX_CFG_GNT,
  output logic                   CORE_TLP_GO,
  input  wire logic              CORE_TLP_SENT,
  // drop report
  output logic                   TX_ERR_DROP,
  // towards the transmit buffer
  output logic [DATA_W-1:0]      TXB_DATA,
  output logic [KEEP_W-1:0]      TXB_KEEP,
  output logic                   TXB_VALID,
  output logic                   TXB_FIRST,
  output logic                   TXB_LAST,
  output logic                   TXB_DISCARD,
  output logic                   TXB_NULLIFY,
  output logic                   TXB_POISON
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tts_state_t        state_q;
  tts_state_t        state_d;
  logic              ready;
  logic              accept;
  logic              first;
  logic              dsc;
  logic              pkt_end;
  logic              grant_take;
  logic              str_q;
  logic              ecrc_q;
  logic              fwd_q;
  logic              lost_q;
  logic              str_now;
  logic              ecrc_now;
  logic              fwd_now;
  logic              lost_now;
  logic              oversize;
  logic              src_gap;
  logic              discard;
  logic              digest;
  logic [DATA_W-1:0] beat_data;
  logic [31:0]       crc;
  logic              drop_q;
  logic [DATA_W-1:0] txb_data_q;
  logic [KEEP_W-1:0] txb_keep_q;
  logic              txb_valid_q;
  logic              txb_first_q;
  logic              txb_last_q;
  logic              txb_discard_q;
  logic              txb_nullify_q;
  logic              txb_poison_q;
  logic              go_q;

  tts_beat_if beat ();

  // ----------------------------------------
  // ready and beat qualification
  // ----------------------------------------
  // grant is honoured only between packets so a started packet never stalls
  assign grant_take = ((state_q == ST_IDLE) | (state_q == ST_DIGEST)) & CORE_TLP_PEND & TX_CFG_GNT;

  always_comb begin
    ready = 1'b0;
    unique case (state_q)
      ST_IDLE:   ready = BUF_ROOM & !PM_NON_D0 & !grant_take;
      ST_PKT:    ready = 1'b1;
      ST_DIGEST: ready = 1'b0;
      ST_CORE:   ready = 1'b0;
    endcase
  end

  assign S_AXIS_TX_TREADY = ready;
  assign TX_CFG_REQ       = CORE_TLP_PEND & (state_q != ST_CORE);

  assign accept  = S_AXIS_TX_TVALID & ready;
  assign first   = accept & (state_q == ST_IDLE);
  // discontinue on the first beat has no packet to act on
  assign dsc     = accept & !first & S_AXIS_TX_TUSER[U_DSC];
  assign pkt_end = accept & (S_AXIS_TX_TLAST | dsc);

  // ----------------------------------------
  // per-packet attributes, current beat merged
  // ----------------------------------------
  assign str_now  = first ? S_AXIS_TX_TUSER[U_STR] : str_q;
  assign ecrc_now = first ? (S_AXIS_TX_TUSER[U_ECRC] & !S_AXIS_TX_TDATA[HDR_TD]) : ecrc_q;
  assign fwd_now  = (fwd_q & !first) | S_AXIS_TX_TUSER[U_FWD];
  assign lost_now = (lost_q & !first) | !LINK_UP;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      str_q  <= 1'b0;
      ecrc_q <= 1'b0;
    end else if (first) begin
      str_q  <= S_AXIS_TX_TUSER[U_STR];
      ecrc_q <= S_AXIS_TX_TUSER[U_ECRC] & !S_AXIS_TX_TDATA[HDR_TD];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) fwd_q <= 1'b0;
    else if (accept) fwd_q <= fwd_now;
  end

  // link loss anywhere inside a packet spoils it, paused beats included
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) lost_q <= 1'b0;
    else if (first) lost_q <= !LINK_UP;
    else if (state_q == ST_PKT && !LINK_UP) lost_q <= 1'b1;
  end

  // ----------------------------------------
  // header edit and beat carrier
  // ----------------------------------------
  always_comb begin
    beat_data = S_AXIS_TX_TDATA;
    if (first && ecrc_now) beat_data[HDR_TD] = 1'b1;
  end

  assign beat.data  = beat_data;
  assign beat.keep  = S_AXIS_TX_TKEEP;
  assign beat.valid = accept;
  assign beat.first = first;
  assign beat.last  = pkt_end;

  tts_ecrc u_ecrc (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .beat  (beat.dst),
    .crc_q (crc)
  );

  tts_pkt_check u_check (
    .clk       (CORE_CLK),
    .rst_n     (RSTN),
    .beat      (beat.dst),
    .raw_valid (S_AXIS_TX_TVALID),
    .in_pkt    (state_q == ST_PKT),
    .stream    (str_q),
    .mps_code  (MPS_CODE),
    .oversize  (oversize),
    .src_gap   (src_gap)
  );

  // ----------------------------------------
  // end-of-packet decisions
  // ----------------------------------------
  assign discard = lost_now | oversize | (str_now & src_gap);
  // a digest is pointless on a packet that will not reach the link intact
  assign digest  = pkt_end & ecrc_now & !discard & !dsc;

  // ----------------------------------------
  // packet state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (grant_take) state_d = ST_CORE;
        else if (digest) state_d = ST_DIGEST;
        else if (first && !pkt_end) state_d = ST_PKT;
      end
      ST_PKT: begin
        if (digest) state_d = ST_DIGEST;
        else if (pkt_end) state_d = ST_IDLE;
      end
      ST_DIGEST: state_d = grant_take ? ST_CORE : ST_IDLE;
      ST_CORE: begin
        if (CORE_TLP_SENT) state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) go_q <= 1'b0;
    else go_q <= grant_take;
  end

  // ----------------------------------------
  // drop pulse, one cycle after the end beat
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) drop_q <= 1'b0;
    else drop_q <= pkt_end & discard;
  end

  // ----------------------------------------
  // transmit buffer beat
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txb_data_q <= '0;
      txb_keep_q <= '0;
      txb_first_q <= 1'b0;
    end else if (accept) begin
      txb_data_q <= beat_data;
      txb_keep_q <= S_AXIS_TX_TKEEP;
      txb_first_q <= first;
    end else if (state_q == ST_DIGEST) begin
      // digest goes out as its own one-dword beat after the data
      txb_data_q <= {96'h0, ~crc};
      txb_keep_q <= KEEP_1DW;
      txb_first_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txb_valid_q <= 1'b0;
      txb_last_q  <= 1'b0;
    end else begin
      txb_valid_q <= accept | (state_q == ST_DIGEST);
      txb_last_q  <= (pkt_end & !digest) | (state_q == ST_DIGEST);
    end
  end

  // stored packets can be dropped in the buffer; cut-through ones already left
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txb_discard_q <= 1'b0;
      txb_nullify_q <= 1'b0;
    end else begin
      txb_discard_q <= pkt_end & !str_now & (dsc | discard);
      txb_nullify_q <= pkt_end & str_now & (dsc | discard);
    end
  end

  // buffer sets EP in the stored header; cut-through headers are gone already
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) txb_poison_q <= 1'b0;
    else txb_poison_q <= (pkt_end & fwd_now & !str_now & !digest)
                         | ((state_q == ST_DIGEST) & fwd_q & !str_q);
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign TX_ERR_DROP = drop_q;
  assign CORE_TLP_GO = go_q;
  assign TXB_DATA    = txb_data_q;
  assign TXB_KEEP    = txb_keep_q;
  assign TXB_VALID   = txb_valid_q;
  assign TXB_FIRST   = txb_first_q;
  assign TXB_LAST    = txb_last_q;
  assign TXB_DISCARD = txb_discard_q;
  assign TXB_NULLIFY = txb_nullify_q;
  assign TXB_POISON  = txb_poison_q;

endmodule : tts_tx_port

// ==== dv/tts_tx_port_chk.sv ====
`timescale 1ns/10ps
module tts_tx_port_chk
  import tts_pkg::*;
(
  // clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RSTN,
  // stream
  input wire logic [DATA_W-1:0] S_AXIS_TX_TDATA,
  input wire logic              S_AXIS_TX_TLAST,
  input wire logic [USER_W-1:0] S_AXIS_TX_TUSER,
  input wire logic              S_AXIS_TX_TVALID,
  input wire logic              S_AXIS_TX_TREADY,
  // core status and arbitration
  input wire logic              BUF_ROOM,
  input wire logic              LINK_UP,
  input wire logic              PM_NON_D0,
  input wire logic              CORE_TLP_PEND,
  input wire logic              TX_CFG_REQ,
  input wire logic              TX_CFG_GNT,
  input wire logic              CORE_TLP_GO,
  input wire logic              CORE_TLP_SENT,
  // results
  input wire logic              TX_ERR_DROP,
  input wire logic [DATA_W-1:0] TXB_DATA,
  input wire logic [KEEP_W-1:0] TXB_KEEP,
  input wire logic              TXB_VALID,
  input wire logic              TXB_LAST,
  input wire logic              TXB_DISCARD,
  input wire logic              TXB_NULLIFY,
  input wire logic              TXB_POISON
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // ----------------------------------------
  // packet tracking
  // ----------------------------------------
  logic acc, first, endb, dig_now;
  logic inp_q, dig_q, gap_q, fwd_q, ld_q, busy_q;
  assign acc     = S_AXIS_TX_TVALID & S_AXIS_TX_TREADY;
  assign first   = acc & !inp_q;
  assign endb    = acc & (S_AXIS_TX_TLAST | (S_AXIS_TX_TUSER[U_DSC] & inp_q));
  assign dig_now = first ? (S_AXIS_TX_TUSER[U_ECRC] & !S_AXIS_TX_TDATA[HDR_TD]) : dig_q;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      inp_q <= 1'b0;
      dig_q <= 1'b0;
      gap_q <= 1'b0;
      fwd_q <= 1'b0;
      ld_q  <= 1'b0;
    end else begin
      if (acc) inp_q <= !endb;
      if (first) begin
        dig_q <= S_AXIS_TX_TUSER[U_ECRC] & !S_AXIS_TX_TDATA[HDR_TD];
        gap_q <= 1'b0;
        fwd_q <= S_AXIS_TX_TUSER[U_FWD];
        ld_q  <= !LINK_UP;
      end else if (inp_q) begin
        gap_q <= gap_q | (S_AXIS_TX_TUSER[U_STR] & !S_AXIS_TX_TVALID);
        fwd_q <= fwd_q | (acc & S_AXIS_TX_TUSER[U_FWD]);
        ld_q  <= ld_q | !LINK_UP;
      end
    end
  end

  // core packet in flight from go until sent
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) busy_q <= 1'b0;
    else if (CORE_TLP_SENT) busy_q <= 1'b0;
    else if (CORE_TLP_GO) busy_q <= 1'b1;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_drop_pulse: assert property (TX_ERR_DROP |=> !TX_ERR_DROP)
    else $error("drop flag longer than one cycle");
  a_no_stall: assert property (inp_q |-> S_AXIS_TX_TREADY)
    else $error("ready low inside a packet");
  a_beat_taken: assert property (acc |=> TXB_VALID && TXB_DATA[127:16] == $past(S_AXIS_TX_TDATA[127:16]))
    else $error("taken beat not forwarded");
  a_full_hold: assert property (!inp_q && !BUF_ROOM |-> !S_AXIS_TX_TREADY)
    else $error("ready high without buffer room");
  a_pm_block: assert property (!inp_q && PM_NON_D0 |-> !S_AXIS_TX_TREADY)
    else $error("ready high in low power state");
  a_grant_go: assert property (!inp_q && TX_CFG_REQ && TX_CFG_GNT |-> !S_AXIS_TX_TREADY ##[1:2] CORE_TLP_GO)
    else $error("grant not followed by go");
  a_core_busy: assert property (busy_q |-> !S_AXIS_TX_TREADY)
    else $error("ready high while core packet in flight");
  a_digest_gap: assert property (endb && dig_now && !S_AXIS_TX_TUSER[U_DSC] |=> TX_ERR_DROP or
    (!S_AXIS_TX_TREADY ##1 (TXB_LAST && TXB_KEEP == KEEP_1DW &&
    (S_AXIS_TX_TREADY || !BUF_ROOM || PM_NON_D0 || CORE_TLP_PEND))))
    else $error("digest insertion gap wrong");
  a_td_set: assert property (first && S_AXIS_TX_TUSER[U_ECRC] |=> TXB_DATA[HDR_TD])
    else $error("digest header bit not set");
  a_dsc_end: assert property (endb && inp_q && S_AXIS_TX_TUSER[U_DSC] |=> TXB_LAST &&
    TXB_NULLIFY == $past(S_AXIS_TX_TUSER[U_STR]) && TXB_DISCARD != $past(S_AXIS_TX_TUSER[U_STR]))
    else $error("discontinue not ending the packet");
  a_dsc_first: assert property (first && S_AXIS_TX_TUSER[U_DSC] && !S_AXIS_TX_TLAST |=>
    !TXB_LAST && !TXB_DISCARD && !TXB_NULLIFY)
    else $error("discontinue on first beat acted on");
  a_gap_drop: assert property (endb && inp_q && gap_q |=> TX_ERR_DROP && TXB_NULLIFY)
    else $error("paused cut-through packet not dropped");
  a_link_drop: assert property (endb && !S_AXIS_TX_TUSER[U_STR] && ((inp_q && ld_q) || !LINK_UP) |=>
    TX_ERR_DROP && TXB_DISCARD)
    else $error("packet during link loss not dropped");
  a_poison_fwd: assert property (endb && !S_AXIS_TX_TUSER[U_STR] && !S_AXIS_TX_TUSER[U_DSC] && !dig_now &&
    ((inp_q && fwd_q) || S_AXIS_TX_TUSER[U_FWD]) |=> TXB_POISON)
    else $error("poison forward not applied");
endmodule : tts_tx_port_chk

bind tts_tx_port tts_tx_port_chk u_chk (.*);

// ==== dv/tts_app_model.sv ====
`timescale 1ns/10ps
module tts_app_model
  import tts_pkg::*;
(
  // clock
  input  wire logic              clk,
  // stream towards the port
  output logic [DATA_W-1:0]      tdata,
  output logic [KEEP_W-1:0]      tkeep,
  output logic                   tlast,
  output logic [USER_W-1:0]      tuser,
  output logic                   tvalid,
  input  wire logic              tready
);
  initial begin
    tdata  = '0;
    tkeep  = KEEP_4DW;
    tlast  = 1'b0;
    tuser  = 4'h0;
    tvalid = 1'b0;
  end

  // ----------------------------------------
  // one packet, optional one-cycle pause before beat gap
  // ----------------------------------------
  task automatic send(input int n, input logic [15:0] kp, input logic [3:0] u, input int gap, input int dsc,
                      input logic [31:0] h0);
    logic r;
    for (int b = 0; b < n; b++) begin
      if (b == gap) begin
        @(negedge clk);
        tvalid = 1'b0;
        tdata  = ~tdata;
      end
      @(negedge clk);
      tvalid = 1'b1;
      tdata  = {{3{32'(b)}}, (b == 0) ? h0 : 32'(b)};
      tlast  = (b == n - 1);
      tkeep  = tlast ? kp : KEEP_4DW;
      tuser  = {(b == dsc), u[2:0]};
      // ready sampled just before the rising edge, where it has settled
      do begin
        #19;
        r = tready;
        @(posedge clk);
        if (!r) @(negedge clk);
      end while (!r);
    end
  endtask : send

  // released bus shows a changing pattern, not the last beat
  task automatic idle();
    @(negedge clk);
    tvalid = 1'b0;
    tlast  = 1'b0;
    tuser  = ~tuser;
    tdata  = ~tdata;
  endtask : idle
endmodule : tts_app_model

// ==== dv/tts_tx_port_tb.sv ====
`timescale 1ns/10ps
module tts_tx_port_tb;
  import tts_pkg::*;

  typedef struct {
    int n; logic [15:0] kp; logic [3:0] u; int gap; int dsc; logic [31:0] h0;
    int beats; int drop; int disc; int nul; int pois; int td; logic [15:0] lk;
  } tts_case_t;

  logic CORE_CLK, RSTN, S_AXIS_TX_TLAST, S_AXIS_TX_TVALID, S_AXIS_TX_TREADY;
  logic [DATA_W-1:0] S_AXIS_TX_TDATA, TXB_DATA;
  logic [KEEP_W-1:0] S_AXIS_TX_TKEEP, TXB_KEEP;
  logic [USER_W-1:0] S_AXIS_TX_TUSER;
  logic [MPS_W-1:0]  MPS_CODE;
  logic BUF_ROOM, LINK_UP, PM_NON_D0, CORE_TLP_PEND, TX_CFG_REQ, TX_CFG_GNT, CORE_TLP_GO, CORE_TLP_SENT;
  logic TX_ERR_DROP, TXB_VALID, TXB_FIRST, TXB_LAST, TXB_DISCARD, TXB_NULLIFY, TXB_POISON;
  logic [15:0] lkeep;
  int failures, checks_done, beats, drops, discs, nulls, poiss, tds, n;

  tts_case_t tbl[11] = '{
    '{3, KEEP_2DW, 4'h0, -1, -1, 32'h0, 3, 0, 0, 0, 0, 0, KEEP_2DW},
    '{3, KEEP_3DW, 4'h0, 1, -1, 32'h0, 3, 0, 0, 0, 0, 0, KEEP_3DW},
    '{3, KEEP_4DW, 4'h4, 1, -1, 32'h0, 3, 1, 0, 1, 0, 0, KEEP_4DW},
    '{3, KEEP_1DW, 4'h0, -1, 2, 32'h0, 3, 0, 1, 0, 0, 0, KEEP_1DW},
    '{3, KEEP_1DW, 4'h4, -1, 2, 32'h0, 3, 0, 0, 1, 0, 0, KEEP_1DW},
    '{2, KEEP_4DW, 4'h0, -1, 0, 32'h0, 2, 0, 0, 0, 0, 0, KEEP_4DW},
    '{2, KEEP_2DW, 4'h2, -1, -1, 32'h0, 2, 0, 0, 0, 1, 0, KEEP_2DW},
    '{2, KEEP_3DW, 4'h1, -1, -1, 32'h0, 3, 0, 0, 0, 0, 1, KEEP_1DW},
    '{2, KEEP_3DW, 4'h1, -1, -1, 32'h8000, 2, 0, 0, 0, 0, 1, KEEP_3DW},
    '{10, KEEP_4DW, 4'h0, -1, -1, 32'h0, 10, 1, 1, 0, 0, 0, KEEP_4DW},
    '{2, KEEP_3DW, 4'h3, -1, -1, 32'h0, 3, 0, 0, 0, 1, 1, KEEP_1DW}
  };

  tts_tx_port dut (.*);
  tts_app_model app (
    .clk    (CORE_CLK),
    .tdata  (S_AXIS_TX_TDATA),
    .tkeep  (S_AXIS_TX_TKEEP),
    .tlast  (S_AXIS_TX_TLAST),
    .tuser  (S_AXIS_TX_TUSER),
    .tvalid (S_AXIS_TX_TVALID),
    .tready (S_AXIS_TX_TREADY)
  );

  always #20 CORE_CLK = ~CORE_CLK;

  // ----------------------------------------
  // buffer-side monitor, sampled mid-cycle
  // ----------------------------------------
  always @(negedge CORE_CLK) begin
    if (TX_ERR_DROP === 1'b1) drops++;
    if (TXB_VALID === 1'b1) begin
      beats++;
      if (TXB_FIRST === 1'b1 && TXB_DATA[HDR_TD] === 1'b1) tds++;
      if (TXB_LAST === 1'b1) begin
        lkeep = TXB_KEEP;
        if (TXB_DISCARD === 1'b1) discs++;
        if (TXB_NULLIFY === 1'b1) nulls++;
        if (TXB_POISON === 1'b1) poiss++;
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic clr();
    {beats, drops, discs, nulls, poiss, tds} = '0;
  endtask : clr

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    failures++;
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    {CORE_CLK, RSTN, PM_NON_D0, CORE_TLP_PEND, TX_CFG_GNT, CORE_TLP_SENT} = '0;
    {BUF_ROOM, LINK_UP} = 2'h3;
    MPS_CODE = 3'h0;
    repeat (4) @(negedge CORE_CLK);
    RSTN = 1'b1;
    foreach (tbl[i]) begin
      clr();
      app.send(tbl[i].n, tbl[i].kp, tbl[i].u, tbl[i].gap, tbl[i].dsc, tbl[i].h0);
      app.idle();
      repeat (6) @(negedge CORE_CLK);
      chk("beats", tbl[i].beats, beats);
      chk("drops", tbl[i].drop, drops);
      chk("discards", tbl[i].disc, discs);
      chk("nullified", tbl[i].nul, nulls);
      chk("poisoned", tbl[i].pois, poiss);
      chk("digest flag", tbl[i].td, tds);
      chk("last keep", tbl[i].lk, lkeep);
    end
    // back-to-back packets held off by full buffer, then by low power
    for (int k = 0; k < 2; k++) begin
      clr();
      fork
        begin
          app.send(2, KEEP_4DW, 4'h0, -1, -1, 32'h0);
          app.send(2, KEEP_2DW, 4'h0, -1, -1, 32'h0);
          app.idle();
        end
        begin
          repeat (2) @(negedge CORE_CLK);
          if (k == 0) BUF_ROOM = 1'b0;
          else PM_NON_D0 = 1'b1;
          repeat (6) @(negedge CORE_CLK);
          chk("held beats", 2, beats);
          chk("tready", 1'b0, S_AXIS_TX_TREADY);
          BUF_ROOM = 1'b1;
          PM_NON_D0 = 1'b0;
        end
      join
      repeat (4) @(negedge CORE_CLK);
      chk("released beats", 4, beats);
    end
    // link loss in mid-packet
    clr();
    fork
      app.send(3, KEEP_3DW, 4'h0, -1, -1, 32'h0);
      begin
        repeat (2) @(negedge CORE_CLK);
        LINK_UP = 1'b0;
        @(negedge CORE_CLK);
        LINK_UP = 1'b1;
      end
    join
    app.idle();
    repeat (6) @(negedge CORE_CLK);
    chk("link drops", 1, drops);
    chk("link discards", 1, discs);
    // core packet arbitration
    CORE_TLP_PEND = 1'b1;
    @(negedge CORE_CLK);
    chk("request", 1'b1, TX_CFG_REQ);
    TX_CFG_GNT = 1'b1;
    @(negedge CORE_CLK);
    TX_CFG_GNT = 1'b0;
    n = 0;
    while (CORE_TLP_GO !== 1'b1 && n < 10) begin
      @(negedge CORE_CLK);
      n++;
    end
    chk("go", 1'b1, CORE_TLP_GO);
    repeat (3) @(negedge CORE_CLK);
    chk("tready busy", 1'b0, S_AXIS_TX_TREADY);
    CORE_TLP_SENT = 1'b1;
    CORE_TLP_PEND = 1'b0;
    @(negedge CORE_CLK);
    CORE_TLP_SENT = 1'b0;
    @(negedge CORE_CLK);
    chk("tready after", 1'b1, S_AXIS_TX_TREADY);
    finish_test();
  end
endmodule : tts_tx_port_tb
